// File: design/fce_spi_fram.sv
// spi slave command engine of a 256k x 8 ferroelectric memory
// assumes pins are asynchronous to clk and the serial clock is at
// least eight times slower than clk
`timescale 1ns/1ps
`default_nettype none
module fce_spi_fram
    import fce_pkg::*;
#(
    // arbitrary neutral identification value
    parameter logic [71:0] ID_CODE = 72'h5a5a5a5a5a5a_a5_1234
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // serial pins
    input wire logic cs_b,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_b,
    input wire logic wp_b,
    output logic so,
    output logic so_oe,
    // status seen by the system
    output logic write_latch_flag,
    output logic protect_pin_enable,
    output logic block_guard_hi,
    output logic block_guard_lo,
    output logic asleep,
    output logic spi_mode3
);

    ////////////////////////////////////////////////////////////////////
    logic [4:0] pin_meta_r;
    logic [4:0] pin_sync_r;
    logic cs_d_r;
    logic sck_d_r;
    logic cs_s, sck_s, si_s, held, wp_s;
    logic cs_fall, cs_rise, sck_rise, sck_fall, byte_done, op_done;
    fce_state_e state_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] rx_r;
    logic [7:0] rx_nxt;
    logic [7:0] tx_r;
    logic so_r;
    logic seen_rise_r;
    logic mode3_r;
    logic [1:0] addr_cnt_r;
    logic [7:0] op_r;
    logic [17:0] mem_addr_r;
    logic [17:0] addr_nxt;
    logic [3:0] id_idx_r;
    logic latch_r, pin_en_r;
    logic [1:0] bp_r;
    logic clr_pend_r, sleep_pend_r;
    logic sleep_r, waking_r;
    logic [7:0] wake_cnt_r;
    logic addr_guarded, sr_ok, sr_byte, sr_wr, mem_we, latch_set_hit;
    logic [7:0] status_byte;
    logic [7:0] mem_r [0:MEM_DEPTH-1];

    function automatic logic [7:0] id_byte(input logic [3:0] idx);
        logic [7:0] b;
        b = 8'h00;
        if (idx < ID_BYTES)
            b = ID_CODE[8 * (int'(ID_BYTES) - 1 - int'(idx)) +: 8];
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // two flops per pin; only the second stage is read
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pin_meta_r <= PIN_IDLE;
            pin_sync_r <= PIN_IDLE;
            cs_d_r <= 1'b1;
            sck_d_r <= 1'b0;
        end
        else
        begin
            pin_meta_r <= {wp_b, hold_b, si, sck, cs_b};
            pin_sync_r <= pin_meta_r;
            cs_d_r <= pin_sync_r[0];
            sck_d_r <= pin_sync_r[1];
        end
    end

    // edge events; hold masks both serial clock edges, sleep only the rising one
    assign cs_s = pin_sync_r[0];
    assign sck_s = pin_sync_r[1];
    assign si_s = pin_sync_r[2];
    assign held = ~pin_sync_r[3];
    assign wp_s = pin_sync_r[4];
    assign cs_fall = cs_d_r & ~cs_s;
    assign cs_rise = ~cs_d_r & cs_s;
    assign sck_rise = ~sck_d_r & sck_s & ~cs_s & ~cs_fall & ~held
        & ~sleep_r;
    assign sck_fall = sck_d_r & ~sck_s & ~cs_s & ~held & seen_rise_r;
    assign rx_nxt = {rx_r[6:0], si_s};
    assign byte_done = sck_rise & (bit_cnt_r == 3'h7);
    assign op_done = byte_done & (state_r == ST_OPCODE);
    assign addr_nxt = {mem_addr_r[9:0], rx_nxt};
    assign latch_set_hit = op_done & (rx_nxt == WRITE_LATCH_SET_CMD);

    // guard field decode
    always_comb
    begin
        case (bp_r)
            2'h0: addr_guarded = 1'b0;
            2'h1: addr_guarded = mem_addr_r >= GUARD_QUARTER_BASE;
            2'h2: addr_guarded = mem_addr_r >= GUARD_HALF_BASE;
            default: addr_guarded = 1'b1;
        endcase
    end

    // pin blocks the status register only, never the array
    assign sr_ok = latch_r & ~(pin_en_r & ~wp_s);
    assign sr_byte = byte_done & (state_r == ST_SR_WRITE);
    assign sr_wr = sr_byte & sr_ok;
    assign mem_we = byte_done & (state_r == ST_WDATA) & latch_r
        & ~addr_guarded;
    assign status_byte = {pin_en_r, 1'b1, 2'h0, bp_r, latch_r, 1'b0};

    ////////////////////////////////////////////////////////////////////
    // frame engine: shifting, decode and address walk
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 3'h0;
            rx_r <= 8'h00;
            tx_r <= 8'h00;
            so_r <= 1'b0;
            seen_rise_r <= 1'b0;
            mode3_r <= 1'b0;
            addr_cnt_r <= 2'h0;
            op_r <= 8'h00;
            mem_addr_r <= 18'h0;
            id_idx_r <= 4'h0;
        end
        else if (cs_fall)
        begin
            // a frame opened while asleep or waking is not trusted
            state_r <= (sleep_r | waking_r) ? ST_IGNORE : ST_OPCODE;
            bit_cnt_r <= 3'h0;
            seen_rise_r <= 1'b0;
            mode3_r <= sck_s;
        end
        else if (cs_s)
        begin
            // deselect drops any partial byte and ends the command
            state_r <= ST_IDLE;
            bit_cnt_r <= 3'h0;
        end
        else if (sck_rise)
        begin
            seen_rise_r <= 1'b1;
            rx_r <= rx_nxt;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (byte_done)
            begin
                case (state_r)
                    ST_OPCODE:
                    begin
                        case (rx_nxt)
                            STATUS_READ_CMD:
                            begin
                                tx_r <= status_byte;
                                state_r <= ST_SR_READ;
                            end
                            STATUS_WRITE_CMD: state_r <= ST_SR_WRITE;
                            MEM_READ_CMD, FAST_READ_CMD, MEM_WRITE_CMD:
                            begin
                                op_r <= rx_nxt;
                                addr_cnt_r <= 2'h0;
                                state_r <= ST_ADDR;
                            end
                            IDENT_READ_CMD:
                            begin
                                tx_r <= id_byte(4'h0);
                                id_idx_r <= 4'h1;
                                state_r <= ST_ID;
                            end
                            default: state_r <= ST_IGNORE;
                        endcase
                    end
                    ST_ADDR:
                    begin
                        mem_addr_r <= addr_nxt;
                        addr_cnt_r <= addr_cnt_r + 2'h1;
                        if (addr_cnt_r == ADDR_LAST_BYTE)
                        begin
                            if (op_r == MEM_READ_CMD)
                            begin
                                tx_r <= mem_r[addr_nxt];
                                mem_addr_r <= addr_nxt + 18'h1;
                                state_r <= ST_RDATA;
                            end
                            else if (op_r == FAST_READ_CMD)
                                state_r <= ST_DUMMY;
                            else
                                state_r <= ST_WDATA;
                        end
                    end
                    ST_DUMMY, ST_RDATA:
                    begin
                        // serial input is not looked at while sending
                        tx_r <= mem_r[mem_addr_r];
                        mem_addr_r <= mem_addr_r + 18'h1;
                        state_r <= ST_RDATA;
                    end
                    ST_WDATA:
                    begin
                        // a guarded location freezes the address
                        if (mem_we)
                            mem_addr_r <= mem_addr_r + 18'h1;
                    end
                    ST_SR_READ: state_r <= ST_IGNORE;
                    ST_SR_WRITE: state_r <= ST_IGNORE;
                    ST_ID:
                    begin
                        tx_r <= id_byte(id_idx_r);
                        if (id_idx_r < ID_BYTES)
                            id_idx_r <= id_idx_r + 4'h1;
                    end
                    default: state_r <= state_r;
                endcase
            end
        end
        else if (sck_fall)
        begin
            // output moves at falling edges, msb first
            so_r <= tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
        end
    end

    // byte stored right after its eighth clock, no page buffer
    always_ff @(posedge clk)
    begin
        if (mem_we)
            mem_r[mem_addr_r] <= rx_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // write latch and status bits
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            latch_r <= 1'b0;
            pin_en_r <= 1'b0;
            bp_r <= BP_RESET;
            clr_pend_r <= 1'b0;
        end
        else
        begin
            if (latch_set_hit)
                latch_r <= 1'b1;
            else if (cs_rise & clr_pend_r)
                latch_r <= 1'b0;
            if (op_done & ((rx_nxt == WRITE_LATCH_CLEAR_CMD)
                | (rx_nxt == STATUS_WRITE_CMD)
                | (rx_nxt == MEM_WRITE_CMD)))
                clr_pend_r <= 1'b1;
            else if (cs_rise)
                clr_pend_r <= 1'b0;
            if (sr_wr)
            begin
                pin_en_r <= rx_nxt[SR_PIN_EN_BIT];
                bp_r <= rx_nxt[SR_BP_HI:SR_BP_LO];
            end
        end
    end

    // sleep entry at deselect, timed wake at the next select
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            sleep_pend_r <= 1'b0;
            sleep_r <= 1'b0;
            waking_r <= 1'b0;
            wake_cnt_r <= 8'h00;
        end
        else
        begin
            if (op_done & (rx_nxt == SLEEP_CMD))
                sleep_pend_r <= 1'b1;
            else if (cs_rise)
                sleep_pend_r <= 1'b0;
            if (cs_rise & sleep_pend_r)
                sleep_r <= 1'b1;
            else if (sleep_r & ~waking_r & cs_fall)
            begin
                waking_r <= 1'b1;
                wake_cnt_r <= WAKE_CYCLES;
            end
            else if (waking_r)
            begin
                wake_cnt_r <= wake_cnt_r - 8'h01;
                if (wake_cnt_r <= 8'h01)
                begin
                    waking_r <= 1'b0;
                    sleep_r <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs; driver enabled only in sending states while selected
    assign so = so_r;
    assign so_oe = ~cs_s & ~held & ~sleep_r
        & ((state_r == ST_SR_READ) | (state_r == ST_RDATA)
        | (state_r == ST_ID));
    assign write_latch_flag = latch_r;
    assign protect_pin_enable = pin_en_r;
    assign block_guard_hi = bp_r[1];
    assign block_guard_lo = bp_r[0];
    assign asleep = sleep_r;
    assign spi_mode3 = mode3_r;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_so_off_deselect;
        cs_rise |=> !so_oe;
    endproperty
    a_so_off_deselect: assert property (p_so_off_deselect)
        else $error("output still driven after deselect");

    property p_sleep_quiet;
        sleep_r |-> !so_oe && !byte_done;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("activity while asleep");

    property p_wake_time;
        (cs_fall && sleep_r && !waking_r) |=> waking_r ##[1:8] !sleep_r;
    endproperty
    a_wake_time: assert property (p_wake_time)
        else $error("wake took too long");

    property p_latch_clear;
        (cs_rise && clr_pend_r) |=> !latch_r;
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("write latch not cleared at frame end");

    property p_latch_cause;
        $rose(latch_r) |-> $past(latch_set_hit);
    endproperty
    a_latch_cause: assert property (p_latch_cause)
        else $error("write latch set without its opcode");

    property p_guard_stall;
        (byte_done && state_r == ST_WDATA && addr_guarded)
            |=> $stable(mem_addr_r);
    endproperty
    a_guard_stall: assert property (p_guard_stall)
        else $error("address moved at guarded location");

    property p_addr_step;
        mem_we |=> mem_addr_r == $past(mem_addr_r) + 18'h1;
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("address did not step after write");

    property p_sr_denied;
        (sr_byte && !sr_ok) |=> $stable(bp_r) && $stable(pin_en_r);
    endproperty
    a_sr_denied: assert property (p_sr_denied)
        else $error("status changed while write blocked");

    property p_sr_taken;
        sr_wr |=> bp_r == rx_r[SR_BP_HI:SR_BP_LO]
            && pin_en_r == rx_r[SR_PIN_EN_BIT];
    endproperty
    a_sr_taken: assert property (p_sr_taken)
        else $error("status write not applied");

    property p_hold_freeze;
        (held && !cs_s && !cs_fall) |=> $stable(bit_cnt_r) && $stable(rx_r);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze)
        else $error("shift advanced during hold");

    property p_mode_catch;
        cs_fall |=> spi_mode3 == $past(sck_s);
    endproperty
    a_mode_catch: assert property (p_mode_catch)
        else $error("mode not caught at select");

    property p_unknown_quiet;
        state_r == ST_IGNORE |-> !so_oe;
    endproperty
    a_unknown_quiet: assert property (p_unknown_quiet)
        else $error("output driven in ignored frame");

    c_read_byte: cover property (byte_done && state_r == ST_RDATA);
    c_mem_write: cover property (mem_we);
    c_sleep: cover property ($rose(sleep_r));
    c_ident: cover property (byte_done && state_r == ST_ID);

endmodule // fce_spi_fram
`default_nettype wire

// File: design/fce_pkg.sv
// constants for the serial ferroelectric memory command engine
// assumes a 10 MHz system clock sampling the serial pins
package fce_pkg;
    // opcodes
    localparam logic [7:0] WRITE_LATCH_SET_CMD = 8'h06;
    localparam logic [7:0] WRITE_LATCH_CLEAR_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] MEM_READ_CMD = 8'h03;
    localparam logic [7:0] FAST_READ_CMD = 8'h0b;
    localparam logic [7:0] MEM_WRITE_CMD = 8'h02;
    localparam logic [7:0] SLEEP_CMD = 8'hb9;
    localparam logic [7:0] IDENT_READ_CMD = 8'h9f;
    // array and address
    localparam int ADDR_W = 18;
    localparam int MEM_DEPTH = 262144;
    localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
    localparam logic [17:0] GUARD_QUARTER_BASE = 18'h30000;
    localparam logic [17:0] GUARD_HALF_BASE = 18'h20000;
    // status byte fields
    localparam int SR_PIN_EN_BIT = 7;
    localparam int SR_BP_HI = 3;
    localparam int SR_BP_LO = 2;
    localparam logic [1:0] BP_RESET = 2'h0;
    // identification
    localparam logic [3:0] ID_BYTES = 4'h9;
    // pin sync order {wp_b, hold_b, si, sck, cs_b} and idle levels
    localparam logic [4:0] PIN_IDLE = 5'h19;
    // wake recovery, a longest time so rounded down
    localparam int CLK_PERIOD_NS = 100;
    localparam int WAKE_RECOVERY_NS = 400;
    localparam logic [7:0] WAKE_CYCLES =
        8'(WAKE_RECOVERY_NS / CLK_PERIOD_NS);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_OPCODE = 4'h1,
        ST_ADDR = 4'h2,
        ST_DUMMY = 4'h3,
        ST_RDATA = 4'h4,
        ST_WDATA = 4'h5,
        ST_SR_READ = 4'h6,
        ST_SR_WRITE = 4'h7,
        ST_ID = 4'h8,
        ST_IGNORE = 4'h9
    } fce_state_e;
endpackage

// File: sim/fce_spi_master.sv
// serial bus master model for the memory command engine
// assumes clk is the bench clock; pins change only at its falling edge
`timescale 1ns/1ps
`default_nettype none
module fce_spi_master (
    // bench clock
    input wire logic clk,
    // serial pins
    output logic cs_b,
    output logic sck,
    output logic si,
    output logic hold_b,
    input wire logic so,
    input wire logic so_oe
);
    logic cpol = 1'h0; // idle clock level, high for mode 3
    logic oe_seen; // device drove the output within the frame
    logic hold_oe; // device drove the output while paused

    ////////////////////////////////////////////////////////////////////////
    // idle pins until the first frame
    initial
    begin
        cs_b = 1'h1;
        sck = 1'h0;
        si = 1'h0;
        hold_b = 1'h1;
    end

    // note any drive while selected, so refusals show up
    always @(posedge clk)
    begin
        if (!cs_b)
            oe_seen <= oe_seen | so_oe;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one bit: fall, present, rise; the device's bit is settled by then
    task automatic bit_x(input logic b, output logic r);
        sck = 1'h0;
        si = b;
        ticks(4);
        sck = 1'h1;
        r = so_oe ? so : ~so; // undriven line reads inverted, stale fails
        ticks(4);
    endtask

    // pause with the clock low, toggle the clock meanwhile, resume
    task automatic pause();
        sck = 1'h0;
        ticks(4);
        hold_b = 1'h0; // clock is low here
        repeat (2)
        begin
            sck = 1'h1;
            ticks(4);
            hold_oe = hold_oe | so_oe;
            sck = 1'h0;
            ticks(4);
        end
        hold_b = 1'h1; // clock still low
        ticks(4);
    endtask

    // whole frame, msb first; optional pause and trailing partial bits
    task automatic frame(input logic [7:0] tx[$], input int hold_at,
        input int part, output logic [7:0] rx[$]);
        logic [7:0] v;
        rx = {};
        oe_seen = 1'h0;
        hold_oe = 1'h0;
        sck = cpol;
        ticks(2);
        cs_b = 1'h0;
        ticks(4);
        foreach (tx[i])
        begin
            for (int k = 7; k >= 0; k--)
                bit_x(tx[i][k], v[k]);
            rx.push_back(v);
            if (i == hold_at)
                pause();
        end
        for (int k = 7; k > 7 - part; k--)
            bit_x(k[0], v[k]);
        sck = cpol;
        ticks(4);
        cs_b = 1'h1; // frames kept apart by far more than 3 clk
        si = ~si; // a released line must not show stale data
        ticks(6);
    endtask
endmodule // fce_spi_master
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the serial memory command engine
// assumes the master model fce_spi_master and a 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb
    import fce_pkg::*;
;
    // arbitrary identification value, not any real code
    localparam logic [71:0] ID_T = 72'h3c3c3c3c3c3c_c3_0f0f;
    logic clk, rst_b, wp_b;
    wire logic cs_b, sck, si, hold_b, so, so_oe;
    wire logic write_latch_flag, protect_pin_enable, asleep, spi_mode3;
    wire logic block_guard_hi, block_guard_lo;
    logic [7:0] rx[$];
    int num_errors = 0;
    int total_checks = 0;

    ////////////////////////////////////////////////////////////////////////
    fce_spi_fram #(.ID_CODE(ID_T)) dut (.clk(clk), .rst_b(rst_b),
        .cs_b(cs_b), .sck(sck), .si(si), .hold_b(hold_b), .wp_b(wp_b),
        .so(so), .so_oe(so_oe), .write_latch_flag(write_latch_flag),
        .protect_pin_enable(protect_pin_enable),
        .block_guard_hi(block_guard_hi), .block_guard_lo(block_guard_lo),
        .asleep(asleep), .spi_mode3(spi_mode3));
    fce_spi_master m (.clk(clk), .cs_b(cs_b), .sck(sck), .si(si),
        .hold_b(hold_b), .so(so), .so_oe(so_oe));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cmd(input logic [7:0] tx[$]);
        m.frame(tx, -1, 0, rx);
    endtask

    // latch always set in a frame of its own first
    task automatic sr_write(input logic [7:0] v);
        cmd('{WRITE_LATCH_SET_CMD}); // separate frame first
        cmd('{STATUS_WRITE_CMD, v});
    endtask

    // expected status byte with the latch clear
    function automatic logic [7:0] sr(input logic w, input logic [1:0] bp);
        return {w, 1'h1, 2'h0, bp, 2'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic t_latch();
        check({write_latch_flag, so_oe, asleep}, 8'h00); // idle
        cmd('{WRITE_LATCH_SET_CMD});
        check(write_latch_flag, 8'h01); // set by opcode
        cmd('{WRITE_LATCH_CLEAR_CMD});
        check(write_latch_flag, 8'h00); // cleared
        cmd('{STATUS_WRITE_CMD, 8'h8c});
        check(protect_pin_enable, 8'h00); // no latch, no write
    endtask

    // protect pin vs array write, wrap, partial byte, paused read
    task automatic t_wp_mem();
        sr_write(8'h80);
        check(protect_pin_enable, 8'h01); // loaded
        check(write_latch_flag, 8'h00); // write clears latch
        wp_b = 1'h0;
        sr_write(8'h8c);
        check(block_guard_hi, 8'h00); // pin blocks status
        cmd('{WRITE_LATCH_SET_CMD}); // own frame first
        cmd('{MEM_WRITE_CMD, 8'hff, 8'hff, 8'hfe, 8'ha1, 8'hb2, 8'hc3,
            8'hd4});
        check(write_latch_flag, 8'h00); // cleared at end
        cmd('{WRITE_LATCH_SET_CMD});
        m.frame('{MEM_WRITE_CMD, 8'h00, 8'h00, 8'h01}, -1, 4, rx);
        m.frame('{MEM_READ_CMD, 8'hc3, 8'hff, 8'hfe, 8'hff, 8'h00, 8'hff,
            8'h00}, 4, 0, rx);
        for (int i = 0; i < 4; i++)
            check(rx[i + 4], 8'ha1 + 8'(i) * 8'h11);
        check(m.hold_oe, 8'h00); // floats while paused
        check(so_oe, 8'h00); // floats after frame
        wp_b = 1'h1; // pin high before status write
        sr_write(8'h00);
        check(protect_pin_enable, 8'h00); // write now allowed
        m.frame('{FAST_READ_CMD, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h55, 8'haa},
            -1, 0, rx);
        check(rx[5], 8'hc3); // after dummy byte
        check(rx[6], 8'hd4); // input toggling ignored
    endtask

    // every guard code, mode 3 status read, guarded burst
    task automatic t_guard();
        logic [1:0] bp;
        for (int i = 0; i < 4; i++)
        begin
            bp = 2'(i + 2);
            sr_write({4'h0, bp, 2'h0});
            check({block_guard_hi, block_guard_lo}, bp);
        end
        m.cpol = 1'h1;
        cmd('{STATUS_READ_CMD, 8'h00});
        check(spi_mode3, 8'h01); // clock high at select
        check(rx[1], sr(1'h0, 2'h1)); // one status byte
        m.cpol = 1'h0;
        cmd('{WRITE_LATCH_SET_CMD});
        check(spi_mode3, 8'h00); // clock low at select
        cmd('{MEM_WRITE_CMD, 8'h03, 8'hff, 8'hfe, 8'h77, 8'h88, 8'h99});
        cmd('{MEM_READ_CMD, 8'h03, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00});
        for (int i = 0; i < 3; i++)
            check(rx[i + 4], 8'ha1 + 8'(i) * 8'h11);
    endtask

    // identification, unknown opcode, sleep and wake
    task automatic t_misc();
        logic [7:0] tx[$];
        tx = '{IDENT_READ_CMD};
        repeat (9) tx.push_back(8'h00);
        cmd(tx);
        for (int i = 0; i < 9; i++)
            check(rx[i + 1], ID_T[71 - 8 * i -: 8]); // nine bytes
        cmd('{8'h77, 8'h00, 8'h00});
        check(m.oe_seen, 8'h00); // never driven
        cmd('{SLEEP_CMD});
        check(asleep, 8'h01); // asleep after select rise
        cmd('{STATUS_READ_CMD, 8'h00}); // wake frame
        check(m.oe_seen, 8'h00); // floats asleep and waking
        check(asleep, 8'h00); // awake again
        cmd('{STATUS_READ_CMD, 8'h00});
        check(rx[1], sr(1'h0, 2'h1)); // normal after wake
    endtask

    ////////////////////////////////////////////////////////////////////////
    // bench clock
    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    // main sequence
    initial
    begin
        rst_b = 1'h0;
        wp_b = 1'h1;
        repeat (2) @(negedge clk);
        rst_b = 1'h1;
        t_latch();
        t_wp_mem();
        t_guard();
        t_misc();
        results();
    end
endmodule // tb
`default_nettype wire
